// file: swm_crc8.sv
/*
 * serial crc-8 checker, one bit per strobe, lsb first.
 * assumes clear and shift are never raised together with meaning.
 */
`timescale 1ns/1ps
`default_nettype none
module swm_crc8
    import swm_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic clear,
    input wire logic shift,
    input wire logic bit_in,
    output logic [7:0] crc
);
    logic [7:0] crc_q;
    logic fb;
    // ==========================================================
    // reflected x^8+x^5+x^4+1 shift register
    assign fb = crc_q[0] ^ bit_in;
    always_ff @(posedge clk) begin
        if (srst || clear) begin
            crc_q <= CRC_INIT;
        end else if (shift) begin
            crc_q <= (crc_q >> 1) ^ (fb ? CRC_POLY_REFLECTED : 8'h00);
        end
    end
    assign crc = crc_q;
endmodule
`default_nettype wire

// file: swm_id_responder.sv
/* behavioural identification responder on the pulled-up line.
   assumes the bench resolves the wire; timing is counted on clk. */
`timescale 1ns/1ps
`default_nettype none
module swm_id_responder
    import swm_pkg::*;
#(
    parameter logic [63:0] ID_WORD = 64'h0,
    parameter int PRES_WAIT_CYC = 150,
    parameter int PRES_LOW_CYC = 600,
    parameter int WR_SAMPLE_CYC = 300,
    parameter int RD_HOLD_CYC = 300
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic enable,
    input wire logic line,
    output logic dev_oe
);
    typedef enum logic [2:0] {M_OFF, M_PRES, M_CMD, M_READ, M_SRCH} swm_mode_t;
    swm_mode_t mode_q;
    logic line_q, tx;
    logic [10:0] low_q, slot_q, pres_q;
    logic [5:0] idx_q;
    logic [1:0] sub_q;
    logic [7:0] cmd_q, cmd_nx;
    assign cmd_nx = {line, cmd_q[7:1]};
    assign tx = (mode_q == M_SRCH && sub_q == 2'h1) ? !ID_WORD[idx_q] : ID_WORD[idx_q];
    // a zero is a pull from the slot start, a one is no pull at all
    assign dev_oe = enable && ((mode_q == M_PRES && pres_q >= PRES_WAIT_CYC &&
        pres_q < PRES_WAIT_CYC + PRES_LOW_CYC) || ((mode_q == M_READ ||
        (mode_q == M_SRCH && sub_q != 2'h2)) && slot_q < RD_HOLD_CYC && !tx));
    // ==========================================================
    // slot timing restarts on every falling edge of the line
    always_ff @(posedge clk) begin
        line_q <= line;
        low_q <= line ? 11'h000 : low_q + {10'h000, low_q != 11'h7FF};
        slot_q <= (line_q && !line) ? 11'h000 : slot_q + {10'h000, slot_q != 11'h7FF};
        if (srst) begin
            mode_q <= M_OFF;
            pres_q <= 11'h000;
        end else if (low_q == 11'(RESPONDER_RESET_CYC)) begin
            mode_q <= M_PRES;
            pres_q <= 11'h000;
            idx_q <= 6'h00;
            sub_q <= 2'h0;
        end else if (mode_q == M_PRES) begin
            pres_q <= pres_q + {10'h000, line || pres_q != 11'h000};
            if (pres_q == 11'(PRES_WAIT_CYC + PRES_LOW_CYC)) mode_q <= M_CMD;
        end else if (slot_q == 11'(WR_SAMPLE_CYC)) begin
            idx_q <= idx_q + 6'h01;
            case (mode_q)
                M_CMD: begin
                    cmd_q <= cmd_nx;
                    if (idx_q == 6'h07) begin
                        idx_q <= 6'h00;
                        mode_q <= (cmd_nx == CMD_READ_ID_A || cmd_nx == CMD_READ_ID_B) ? M_READ :
                            (cmd_nx == CMD_SEARCH ? M_SRCH : M_OFF);
                    end
                end
                M_READ: if (idx_q == 6'h3F) mode_q <= M_OFF;
                M_SRCH: begin
                    sub_q <= (sub_q == 2'h2) ? 2'h0 : sub_q + 2'h1;
                    if (sub_q != 2'h2) idx_q <= idx_q;
                    else if (line != ID_WORD[idx_q] || idx_q == 6'h3F) mode_q <= M_OFF;
                end
                default: idx_q <= idx_q;
            endcase
        end
    end
endmodule
`default_nettype wire

// file: swm_master.sv
/*
 * single-wire bus master: reset/presence, read identity, one search pass,
 * or a bare command byte. drives the open-drain line via line_oe only.
 * assumes an external pull-up resolves the line; line_in is asynchronous.
 */
// Overview of operation
// - crc uses x^8+x^5+x^4+1
// - crc starts zero, lsb first
// - crc over all 64 gives zero
// - open-drain line, wired-and, pull-up idle
// - idle high; long low resets
// - master bit rate at most 16.3kbps
// - every transaction starts with reset/presence
// - eight-bit command after presence
// - search: bit, complement, master write
// - stretch reset low by fall time
// - sample presence at fixed point
// - write-one releases early, write-zero holds
// - allow recovery between slots
// - sample read early, finish slot
// - wait reset-high before next activity
// - keep reset low under 960us
`timescale 1ns/1ps
`default_nettype none
module swm_master
    import swm_pkg::*;
#(
    parameter int RESET_LOW_CYCLES = RESET_LOW_CYC,
    parameter int RESET_HIGH_CYCLES = RESET_HIGH_CYC
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic start,
    input wire logic [1:0] op,
    input wire logic [7:0] cmd_byte,
    input wire logic [63:0] search_choice,
    output logic busy,
    output logic done,
    output logic present,
    output logic crc_ok,
    output logic search_fail,
    output logic [63:0] id_word,
    input wire logic line_in,
    output logic line_out,
    output logic line_oe
);
    // ==========================================================
    // elaboration checks
    if (RESET_LOW_CYCLES < 2 || RESET_LOW_CYCLES > 65536 ||
            RESET_HIGH_CYCLES < PRESENCE_SAMPLE_CYC + 1 ||
            RESET_HIGH_CYCLES > 65536) begin : g_bad_counts
        $error("reset counts out of range");
    end

    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_RST_LOW = 7'b0000010,
        ST_RST_HIGH = 7'b0000100,
        ST_SLOT_LOW = 7'b0001000,
        ST_SLOT_REST = 7'b0010000,
        ST_NEXT = 7'b0100000,
        ST_DONE = 7'b1000000
    } swm_state_t;

    typedef enum logic [3:0] {
        PH_CMD = 4'b0001,
        PH_READ = 4'b0010,
        PH_SRCH_RD = 4'b0100,
        PH_SRCH_WR = 4'b1000
    } swm_phase_t;

    // ==========================================================
    // line synchroniser: first stage feeds only the second
    logic sync1_q, sync2_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end else begin
            sync1_q <= line_in;
            sync2_q <= sync1_q;
        end
    end

    swm_state_t state_q;
    swm_phase_t phase_q;
    logic [1:0] op_q;
    logic [7:0] cmd_q;
    logic [63:0] choice_q;
    logic [63:0] id_q;
    logic [15:0] cnt_q;
    logic [6:0] bit_q;
    logic tx_bit_q;
    logic is_read_q;
    logic rd_true_q, rd_val_q;
    logic present_q, done_q, fail_q, srch_true_q;
    logic crc_clear, crc_shift;
    logic [7:0] crc_val;
    logic [15:0] low_len;
    logic slot_end;

    // slot geometry: read slots and write-one slots release early
    always_comb begin
        if (is_read_q) begin
            low_len = 16'(READ_LOW_CYC);
        end else if (tx_bit_q) begin
            low_len = 16'(WRITE_ONE_LOW_CYC);
        end else begin
            low_len = 16'(WRITE_ZERO_LOW_CYC);
        end
    end
    // full slot plus recovery keeps the rate well under 16.3 kbps
    assign slot_end = (cnt_q == 16'(SLOT_CYC + RECOVERY_CYC - 1));

    // ==========================================================
    // main sequencer
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= ST_IDLE;
            phase_q <= PH_CMD;
            op_q <= OP_RESET;
            cmd_q <= 8'h00;
            choice_q <= 64'h0;
            cnt_q <= 16'h0;
            bit_q <= 7'h00;
            tx_bit_q <= 1'b1;
            is_read_q <= 1'b0;
            rd_true_q <= 1'b0;
            rd_val_q <= 1'b1;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        op_q <= op;
                        choice_q <= search_choice;
                        unique case (op)
                            OP_READ_ID: cmd_q <= CMD_READ_ID_A;
                            OP_SEARCH: cmd_q <= CMD_SEARCH;
                            default: cmd_q <= cmd_byte;
                        endcase
                        cnt_q <= 16'h0;
                        state_q <= ST_RST_LOW;
                    end
                end
                ST_RST_LOW: begin
                    // held for reset low plus fall time, not longer
                    if (cnt_q == 16'(RESET_LOW_CYCLES - 1)) begin
                        cnt_q <= 16'h0;
                        state_q <= ST_RST_HIGH;
                    end else begin
                        cnt_q <= cnt_q + 16'h1;
                    end
                end
                ST_RST_HIGH: begin
                    // nothing new until reset-high time has passed
                    if (cnt_q == 16'(RESET_HIGH_CYCLES - 1)) begin
                        cnt_q <= 16'h0;
                        bit_q <= 7'h00;
                        phase_q <= PH_CMD;
                        if (!present_q || op_q == OP_RESET) begin
                            state_q <= ST_DONE;
                        end else begin
                            is_read_q <= 1'b0;
                            tx_bit_q <= cmd_q[0];
                            state_q <= ST_SLOT_LOW;
                        end
                    end else begin
                        cnt_q <= cnt_q + 16'h1;
                    end
                end
                ST_SLOT_LOW: begin
                    // each slot opens with our falling edge
                    cnt_q <= cnt_q + 16'h1;
                    if (cnt_q == low_len - 16'h1) begin
                        state_q <= ST_SLOT_REST;
                    end
                end
                ST_SLOT_REST: begin
                    cnt_q <= cnt_q + 16'h1;
                    if (is_read_q && cnt_q == 16'(READ_SAMPLE_CYC)) begin
                        rd_val_q <= sync2_q;
                    end
                    if (slot_end) begin
                        state_q <= ST_NEXT;
                    end
                end
                ST_NEXT: begin
                    cnt_q <= 16'h0;
                    state_q <= ST_SLOT_LOW;
                    unique case (phase_q)
                        PH_CMD: begin
                            if (bit_q == 7'(CMD_BITS - 1)) begin
                                bit_q <= 7'h00;
                                is_read_q <= (op_q != OP_COMMAND);
                                if (op_q == OP_SEARCH) begin
                                    phase_q <= PH_SRCH_RD;
                                end else if (op_q == OP_READ_ID) begin
                                    phase_q <= PH_READ;
                                end else begin
                                    state_q <= ST_DONE;
                                end
                            end else begin
                                bit_q <= bit_q + 7'h1;
                                tx_bit_q <= cmd_q[3'(bit_q + 7'h1)];
                            end
                        end
                        PH_READ: begin
                            if (bit_q == 7'(ID_BITS - 1)) begin
                                state_q <= ST_DONE;
                            end
                            bit_q <= bit_q + 7'h1;
                        end
                        PH_SRCH_RD: begin
                            // triplet: true bit, complement, then our write
                            if (!rd_true_q) begin
                                rd_true_q <= 1'b1;
                            end else begin
                                rd_true_q <= 1'b0;
                                is_read_q <= 1'b0;
                                tx_bit_q <= choice_q[bit_q[5:0]];
                                phase_q <= PH_SRCH_WR;
                                // both reads high: nobody left, so the pass stops here
                                // rather than spending three slots on every bit left
                                if (srch_true_q && rd_val_q) begin
                                    state_q <= ST_DONE;
                                end
                            end
                        end
                        PH_SRCH_WR: begin
                            is_read_q <= 1'b1;
                            phase_q <= PH_SRCH_RD;
                            if (bit_q == 7'(ID_BITS - 1)) begin
                                state_q <= ST_DONE;
                            end
                            bit_q <= bit_q + 7'h1;
                        end
                        default: state_q <= ST_DONE;
                    endcase
                end
                ST_DONE: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // presence sampled at a fixed point after release
    always_ff @(posedge clk) begin
        if (srst) begin
            present_q <= 1'b0;
        end else if (state_q == ST_RST_HIGH && cnt_q == 16'(PRESENCE_SAMPLE_CYC)) begin
            present_q <= !sync2_q;
        end
    end

    // ==========================================================
    // identity capture; search records the chosen path
    always_ff @(posedge clk) begin
        if (srst) begin
            id_q <= 64'h0;
            srch_true_q <= 1'b1;
            fail_q <= 1'b0;
        end else if (state_q == ST_IDLE && start) begin
            id_q <= 64'h0;
            fail_q <= 1'b0;
        end else if (state_q == ST_NEXT) begin
            if (phase_q == PH_READ) begin
                id_q[bit_q[5:0]] <= rd_val_q;
            end else if (phase_q == PH_SRCH_RD && !rd_true_q) begin
                srch_true_q <= rd_val_q;
            end else if (phase_q == PH_SRCH_RD) begin
                id_q[bit_q[5:0]] <= choice_q[bit_q[5:0]];
                // both reads high: nobody left in the search
                if (srch_true_q && rd_val_q) begin
                    fail_q <= 1'b1;
                end
            end
        end
    end

    // crc over the 64 collected bits must end at zero
    assign crc_clear = (state_q == ST_IDLE);
    assign crc_shift = (state_q == ST_NEXT) &&
        (phase_q == PH_READ || (phase_q == PH_SRCH_RD && rd_true_q));
    swm_crc8 u_crc (
        .clk(clk),
        .srst(srst),
        .clear(crc_clear),
        .shift(crc_shift),
        .bit_in(phase_q == PH_READ ? rd_val_q : choice_q[bit_q[5:0]]),
        .crc(crc_val)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            done_q <= 1'b0;
        end else begin
            done_q <= (state_q == ST_DONE);
        end
    end

    // ==========================================================
    // outputs; line only ever pulled low, never driven high
    assign line_out = 1'b0;
    assign line_oe = (state_q == ST_RST_LOW) || (state_q == ST_SLOT_LOW);
    assign busy = (state_q != ST_IDLE);
    assign done = done_q;
    assign present = present_q;
    assign search_fail = fail_q;
    assign crc_ok = (crc_val == 8'h00) && (id_q != 64'h0);
    assign id_word = id_q;
endmodule
`default_nettype wire

// file: swm_master_sva.sv
/* assertions on the ports of the single-wire bus master.
   assumes one clock domain, sync reset srst, and the bind at the foot. */
`timescale 1ns/1ps
`default_nettype none
module swm_master_chk
    import swm_pkg::*;
#(
    parameter int RESET_LOW_CYCLES = RESET_LOW_CYC,
    parameter int RESET_HIGH_CYCLES = RESET_HIGH_CYC
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic start,
    input wire logic busy,
    input wire logic line_out,
    input wire logic line_oe
);
    logic [15:0] run_q, idle_q, per_q;
    logic oe_q, rst_q, fell;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    assign fell = !line_oe && oe_q;
    // ==========================================================
    // pull, release and rise-to-rise counters; idle saturates
    always_ff @(posedge clk) begin
        if (srst) begin
            run_q <= 16'h0000;
            idle_q <= 16'hFFFF;
            per_q <= 16'hFFFF;
            oe_q <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            oe_q <= line_oe;
            run_q <= line_oe ? run_q + 16'h0001 : 16'h0000;
            idle_q <= line_oe ? 16'h0000 : idle_q + {15'h0000, idle_q != 16'hFFFF};
            per_q <= (line_oe && !oe_q) ? 16'h0001 : per_q + {15'h0000, per_q != 16'hFFFF};
            rst_q <= line_oe ? 1'b0 : ((fell && run_q > 16'h04B0) || rst_q);
        end
    end
    // ==========================================================
    // assertions
    chk_pull_only: assert property (line_oe |-> !line_out)
        else $error("line driven high");
    chk_start_reset: assert property (start && !busy |=> busy && line_oe)
        else $error("start did not open a reset pulse");
    chk_idle_free: assert property (!busy |-> !line_oe)
        else $error("line pulled while idle");
    chk_reset_len: assert property (fell && run_q > 16'h04B0 |->
        run_q >= RESET_LOW_CYCLES && run_q <= 16'h2580) else $error("reset pulse length");
    chk_short_low: assert property (fell && run_q < 16'h00C8 |->
        run_q >= 16'h000A && run_q <= 16'h0096) else $error("short low out of window");
    chk_zero_low: assert property (fell && run_q >= 16'h00C8 && run_q <= 16'h04B0 |->
        run_q >= WRITE_ZERO_LOW_CYC) else $error("write zero too short");
    chk_slot_recovery: assert property ($rose(line_oe) |-> idle_q >= RECOVERY_CYC)
        else $error("recovery too short");
    chk_slot_rate: assert property ($rose(line_oe) |-> per_q >= 16'h0266)
        else $error("slots too close");
    chk_reset_gap: assert property ($rose(line_oe) && rst_q |->
        idle_q >= RESET_HIGH_CYCLES) else $error("slot inside reset high time");
    cover property ($fell(busy));
    cover property ($rose(line_oe) && rst_q);
    cover property (fell && run_q >= WRITE_ZERO_LOW_CYC && run_q <= 16'h04B0);
endmodule
bind swm_master swm_master_chk #(.RESET_LOW_CYCLES(RESET_LOW_CYCLES),
    .RESET_HIGH_CYCLES(RESET_HIGH_CYCLES)) chk_inst (.clk(clk), .srst(srst),
    .start(start), .busy(busy), .line_out(line_out), .line_oe(line_oe));
`default_nettype wire

// file: swm_master_tb.sv
/* self-checking bench: bus master, one responder, pull-up line.
   assumes the package constants; reset pulse shortened to 130us. */
`timescale 1ns/1ps
`default_nettype none
module swm_master_tb
    import swm_pkg::*;
;
    localparam int RL = 1300; // above the responder reset threshold
    localparam int RH = 800;
    localparam logic [7:0] FAMILY = 8'h5A; // arbitrary value
    localparam logic [47:0] SERIAL = 48'h0123456789AB; // arbitrary value
    function automatic logic [7:0] crc_of(input logic [63:0] d, input int n);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < n; i++) begin
            c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8C : 8'h00);
        end
        return c;
    endfunction
    localparam logic [63:0] ROM = {crc_of({8'h00, SERIAL, FAMILY}, 56), SERIAL, FAMILY};
    typedef struct packed {logic [1:0] op; logic [7:0] cmd; logic en; logic pres;} swm_row_t;
    swm_row_t rows [5] = '{'{OP_RESET, 8'h00, 1'b1, 1'b1}, '{OP_RESET, 8'h00, 1'b0, 1'b0},
        '{OP_COMMAND, 8'h55, 1'b1, 1'b1}, '{OP_COMMAND, 8'hCC, 1'b1, 1'b1},
        '{OP_COMMAND, 8'h0F, 1'b1, 1'b1}};
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic start = 1'b0;
    logic [1:0] op = 2'h0;
    logic [7:0] cmd_byte = 8'h00;
    logic [63:0] search_choice = 64'h0;
    logic dev_en = 1'b1;
    logic busy, done, present, crc_ok, search_fail, line_out, line_oe, dev_oe;
    logic [63:0] id_word;
    int err_count = 0;
    int n_compared = 0;
    wire line = (line_oe ? line_out : 1'b1) & !dev_oe; // pull-up gives wired-and
    swm_master #(.RESET_LOW_CYCLES(RL), .RESET_HIGH_CYCLES(RH)) swm_master_inst (
        .clk(clk), .srst(srst), .start(start), .op(op), .cmd_byte(cmd_byte),
        .search_choice(search_choice), .busy(busy), .done(done), .present(present),
        .crc_ok(crc_ok), .search_fail(search_fail), .id_word(id_word),
        .line_in(line), .line_out(line_out), .line_oe(line_oe));
    swm_id_responder #(.ID_WORD(ROM)) swm_id_responder_inst (
        .clk(clk), .srst(srst), .enable(dev_en), .line(line), .dev_oe(dev_oe));
    always #50 clk = !clk;
    // ==========================================================
    // shared tasks
    task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("ERROR %s expected %0h seen %0h", name, exp, got);
            err_count++;
        end
    endtask
    task automatic close_out();
        if (err_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // poke re-raises start mid-run, which a busy master must ignore
    task automatic run_op(input logic [1:0] o, input logic [7:0] c, input logic [63:0] ch,
                          input int poke, output int n);
        @(posedge clk);
        #10;
        op = o;
        cmd_byte = c;
        search_choice = ch;
        start = 1'b1;
        n = 0;
        @(posedge clk);
        #10;
        while (done !== 1'b1 && n < 60000) begin
            start = (n == poke);
            @(posedge clk);
            #10;
            n++;
        end
        start = 1'b0;
        if (n >= 60000) begin
            check("done", 64'h1, {63'h0, done});
            close_out();
        end
    endtask
    // ==========================================================
    // main sequence
    initial begin
        int n;
        repeat (5) @(posedge clk);
        #10;
        srst = 1'b0;
        foreach (rows[i]) begin
            dev_en = rows[i].en;
            run_op(rows[i].op, rows[i].cmd, 64'h0, -1, n);
            check("present", {63'h0, rows[i].pres}, {63'h0, present});
        end
        // no presence: the master gives up after the reset phase
        dev_en = 1'b0;
        run_op(OP_READ_ID, 8'h00, 64'h0, -1, n);
        check("short run", 64'h1, {63'h0, n <= RL + RH + 20});
        dev_en = 1'b1;
        // responder was left waiting for a command byte above; this reset must still bring it back
        run_op(OP_READ_ID, 8'h00, 64'h0, 9000, n);
        check("id_word", ROM, id_word);
        check("crc_ok", 64'h1, {63'h0, crc_ok});
        check("crc over id", 64'h0, {56'h0, crc_of(id_word, 64)});
        check("read length", 64'h1, {63'h0, n >= RL + RH + 72 * SLOT_CYC});
        check("search_fail", 64'h0, {63'h0, search_fail});
        // wrong first choice: responder drops out, both later reads come back high
        run_op(OP_SEARCH, 8'h00, ~ROM, -1, n);
        check("search_fail", 64'h1, {63'h0, search_fail});
        // reset in the middle of a reset pulse: the line must be let go at once
        @(posedge clk);
        #10;
        op = OP_READ_ID;
        start = 1'b1;
        @(posedge clk);
        #10;
        start = 1'b0;
        repeat (1000) @(posedge clk);
        #10;
        check("line_oe before srst", 64'h1, {63'h0, line_oe});
        srst = 1'b1;
        @(posedge clk);
        #10;
        srst = 1'b0;
        check("busy after srst", 64'h0, {63'h0, busy});
        check("line_oe after srst", 64'h0, {63'h0, line_oe});
        check("present after srst", 64'h0, {63'h0, present});
        close_out();
    end
endmodule
`default_nettype wire

// file: swm_pkg.sv
/*
 * package for the single-wire bus master: slot timing, command codes, widths.
 * assumes a 10 MHz system clock; all times are in nanoseconds.
 */
package swm_pkg;
    localparam int CLK_PERIOD_NS = 100;
    // ==========================================================
    // bus timing in ns, as printed
    localparam int RESET_LOW_TIME_NS = 480_000;
    localparam int RESET_HIGH_TIME_NS = 480_000;
    localparam int PRESENCE_SAMPLE_POINT_NS = 70_000;
    localparam int WRITE_ONE_LOW_TIME_NS = 6_000;
    localparam int WRITE_ZERO_LOW_TIME_NS = 60_000;
    localparam int READ_LOW_TIME_NS = 2_000;
    localparam int READ_SAMPLE_POINT_NS = 13_000;
    localparam int SLOT_DURATION_NS = 65_000;
    localparam int SLOT_RECOVERY_TIME_NS = 5_000;
    localparam int FALL_TIME_NS = 0;
    localparam int RESPONDER_RESET_NS = 120_000;
    // ==========================================================
    // cycle counts: least times round up, longest round down
    localparam int RESET_LOW_CYC =
        (RESET_LOW_TIME_NS + FALL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_HIGH_CYC = (RESET_HIGH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PRESENCE_SAMPLE_CYC = PRESENCE_SAMPLE_POINT_NS / CLK_PERIOD_NS;
    localparam int WRITE_ONE_LOW_CYC = WRITE_ONE_LOW_TIME_NS / CLK_PERIOD_NS;
    localparam int WRITE_ZERO_LOW_CYC =
        (WRITE_ZERO_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_LOW_CYC = (READ_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_SAMPLE_CYC = READ_SAMPLE_POINT_NS / CLK_PERIOD_NS;
    localparam int SLOT_CYC = (SLOT_DURATION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVERY_CYC = (SLOT_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESPONDER_RESET_CYC = RESPONDER_RESET_NS / CLK_PERIOD_NS;
    // ==========================================================
    // identification word and commands
    localparam int ID_BITS = 64;
    localparam int CRC_BITS = 8;
    localparam int CMD_BITS = 8;
    localparam logic [7:0] CMD_READ_ID_A = 8'h33;
    localparam logic [7:0] CMD_READ_ID_B = 8'h0F;
    localparam logic [7:0] CMD_SEARCH = 8'hF0;
    localparam logic [7:0] CRC_POLY_REFLECTED = 8'h8C;
    localparam logic [7:0] CRC_INIT = 8'h00;
    localparam logic [1:0] OP_RESET = 2'h0;
    localparam logic [1:0] OP_READ_ID = 2'h1;
    localparam logic [1:0] OP_SEARCH = 2'h2;
    localparam logic [1:0] OP_COMMAND = 2'h3;
endpackage
